/* hw/dps_edge.sv */
/*
 * rise detector for one sampled clock-like pin.
 * assumes the pin is already synchronous to clk.
 */
`timescale 1ns/1ns
module dps_edge (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic level,
    output logic      rise
);
    logic prev_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_ff <= 1'h1;
        end else begin
            prev_ff <= level;
        end
    end

    // reset to one so a pin held high at release is not a rise
    assign rise = level & ~prev_ff;
endmodule : dps_edge

/* hw/dps_pkg.sv */
/*
 * constants, state encoding and port-level figures for the two-port
 * double-data-rate burst memory port logic.
 * assumes one system clock; the documented clock pins arrive as
 * levels sampled on that clock and their rises are found by edge detect.
 */
// Operation
// - strap high: read data 1.5 input clock cycles after request
// - strap low: legacy mode, read data one clock after the request
// - strap driven low turns the internal pll off
// - every read or write access starts on an input_timing_pos rise
// - outputs timed by output pair, input pair in single-clock mode
// - write data captured on rises of both input clocks
// - read data register updates only on rises of the pair that times outputs
// - read, write and byte-lane selects registered on input rises
// - read data only on read bus, write data only on write bus
// - one address bus shared; each port latches it on its own edge
// - read: select low at input_pos rise latches address
// - write: word0 at input_pos rise, address and word1 at neg rise
// - lane enables sampled per word; disabled lanes keep stored bytes
// - deselected read port finishes, tristates after next output pos rise
package dps_pkg;
    localparam int unsigned WORD_W        = 18;
    localparam int unsigned LANES         = 2;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned LEGACY_MAX_MHZ = 167;
    localparam logic        STRAP_RST     = 1'h1;

    // gray along idle -> lower -> upper -> tail -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LO   = 2'h1,
        ST_HI   = 2'h3,
        ST_TAIL = 2'h2
    } dps_rd_e;
endpackage : dps_pkg

/* hw/dps_port.sv */
/*
 * read and write port logic of a two-port burst memory with a shared
 * address bus, two-word bursts and a latency strap.
 * assumes the controller drives all pins synchronous to clk, and that
 * each documented clock pin changes level at most once per clk cycle.
 */
`timescale 1ns/1ns
module dps_port #(
    parameter int unsigned W  = dps_pkg::WORD_W,
    parameter int unsigned NL = dps_pkg::LANES,
    parameter int unsigned AW = dps_pkg::ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          pll_bypass_n,
    input  wire logic          single_clock_mode,
    input  wire logic          input_timing_pos,
    input  wire logic          input_timing_neg,
    input  wire logic          output_timing_pos,
    input  wire logic          output_timing_neg,
    input  wire logic          read_select_n,
    input  wire logic          write_select_n,
    input  wire logic [NL-1:0] byte_lane_enable_n,
    input  wire logic [AW-1:0] address,
    input  wire logic [W-1:0]  write_value_in,
    output logic      [W-1:0]  read_data_out,
    output logic               read_data_oe,
    output logic               echo_strobe_pos,
    output logic               echo_strobe_neg,
    output logic               pll_enabled
);
    localparam int unsigned LW = W / NL;

    typedef struct packed {
        logic            pll_on;
        logic            single;
        dps_pkg::dps_rd_e st;
        logic            rd_pend_v;
        logic [AW-1:0]   rd_pend_a;
        logic [AW-1:0]   rd_act_a;
        logic            wr_pend;
        logic [W-1:0]    wr_d0;
        logic [NL-1:0]   wr_be0;
        logic [W-1:0]    dout;
        logic            doe;
        logic            echo_p;
        logic            echo_n;
    } dps_state_s;

    dps_state_s s_ff;
    dps_state_s nxt_s;
    logic [W-1:0] mem [0:(2**(AW+1))-1];

    logic kp_r;
    logic kn_r;
    logic op_r;
    logic on_r;
    logic out_p;
    logic out_n;
    logic lo_edge;
    logic hi_edge;
    logic wr_go;
    logic start;
    logic [AW-1:0] act_a;
    dps_pkg::dps_rd_e st_now;

    ////////////////////////////////////////////////////////////////////
    dps_edge u_kp (.clk(clk), .srst(srst), .level(input_timing_pos),
                   .rise(kp_r));
    dps_edge u_kn (.clk(clk), .srst(srst), .level(input_timing_neg),
                   .rise(kn_r));
    dps_edge u_op (.clk(clk), .srst(srst), .level(output_timing_pos),
                   .rise(op_r));
    dps_edge u_on (.clk(clk), .srst(srst), .level(output_timing_neg),
                   .rise(on_r));

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s = s_ff;
        // single-clock mode reuses the input pair for output timing
        out_p = s_ff.single ? kp_r : op_r;
        out_n = s_ff.single ? kn_r : on_r;
        lo_edge = s_ff.pll_on ? out_n : out_p;
        hi_edge = s_ff.pll_on ? out_p : out_n;
        nxt_s.echo_p = s_ff.single ? input_timing_pos : output_timing_pos;
        nxt_s.echo_n = s_ff.single ? input_timing_neg : output_timing_neg;

        // write port: word0 on pos rise, address and word1 on neg rise
        wr_go = kn_r & s_ff.wr_pend;
        if (wr_go) begin
            nxt_s.wr_pend = 1'h0;
        end
        if (kp_r) begin
            nxt_s.wr_pend = ~write_select_n;
            nxt_s.wr_d0   = write_value_in;
            nxt_s.wr_be0  = byte_lane_enable_n;
        end

        // read port: request latched, burst starts at the next pos rise
        start = kp_r & s_ff.rd_pend_v;
        act_a = start ? s_ff.rd_pend_a : s_ff.rd_act_a;
        st_now = start ? dps_pkg::ST_LO : s_ff.st;
        nxt_s.rd_act_a = act_a;
        if (kp_r) begin
            nxt_s.rd_pend_v = ~read_select_n;
            nxt_s.rd_pend_a = address;
        end
        nxt_s.st = st_now;
        case (st_now)
            dps_pkg::ST_LO: begin
                if (lo_edge) begin
                    nxt_s.dout = mem[{act_a, 1'h0}];
                    nxt_s.doe  = 1'h1;
                    nxt_s.st   = dps_pkg::ST_HI;
                end
            end
            dps_pkg::ST_HI: begin
                if (hi_edge) begin
                    nxt_s.dout = mem[{act_a, 1'h1}];
                    nxt_s.st   = dps_pkg::ST_TAIL;
                end
            end
            dps_pkg::ST_TAIL: begin
                // a following read keeps the bus driven with no gap
                if (out_p) begin
                    nxt_s.doe = 1'h0;
                    nxt_s.st  = dps_pkg::ST_IDLE;
                end
            end
            dps_pkg::ST_IDLE: begin
                nxt_s.doe = 1'h0;
            end
            default: begin
                nxt_s.st  = dps_pkg::ST_IDLE;
                nxt_s.doe = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.st <= dps_pkg::ST_IDLE;
            // straps are caught while reset is held and frozen after
            s_ff.pll_on <= pll_bypass_n;
            s_ff.single <= single_clock_mode;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the array is commited only at the neg rise, so a read in the same
    // cycle sees the old words; no forwarding at this clock rate
    always_ff @(posedge clk) begin
        if (wr_go) begin
            for (int l = 0; l < NL; l++) begin
                if (!s_ff.wr_be0[l]) begin
                    mem[{address, 1'h0}][l*LW +: LW] <=
                        s_ff.wr_d0[l*LW +: LW];
                end
                if (!byte_lane_enable_n[l]) begin
                    mem[{address, 1'h1}][l*LW +: LW] <=
                        write_value_in[l*LW +: LW];
                end
            end
        end
    end

    // separate buses: read data never shares pins with write data
    assign read_data_out   = s_ff.dout;
    assign read_data_oe    = s_ff.doe;
    assign echo_strobe_pos = s_ff.echo_p;
    assign echo_strobe_neg = s_ff.echo_n;
    assign pll_enabled     = s_ff.pll_on;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence rd_req_s;
        kp_r && !read_select_n;
    endsequence
    sequence wr_full_s;
        wr_go && byte_lane_enable_n == '0;
    endsequence
    sequence hi_launch_s;
        st_now == dps_pkg::ST_HI && hi_edge;
    endsequence

    strap_stable_a: assert property (
        !$past(srst) |-> $stable(pll_enabled))
        else $error("pll strap changed after reset");
    req_latch_a: assert property (
        rd_req_s |=> s_ff.rd_pend_v && s_ff.rd_pend_a == $past(address))
        else $error("read request not latched");
    wr_start_a: assert property (
        $rose(s_ff.wr_pend) |-> $past(kp_r))
        else $error("write started off a pos rise");
    wr_word1_a: assert property (
        wr_full_s |=>
        mem[{$past(address), 1'h1}] == $past(write_value_in))
        else $error("second write word not stored");
    lane_keep_a: assert property (
        wr_go && byte_lane_enable_n[0] |=>
        mem[{$past(address), 1'h1}][LW-1:0] ==
        $past(mem[{address, 1'h1}][LW-1:0]))
        else $error("disabled lane was written");
    lower_edge_a: assert property (
        $rose(read_data_oe) |-> $past(s_ff.pll_on ? out_n : out_p))
        else $error("lower word on wrong edge");
    legacy_lat_a: assert property (
        !s_ff.pll_on && start && out_p |=>
        read_data_oe && read_data_out == mem[{s_ff.rd_act_a, 1'h0}])
        else $error("legacy lower word not one clock after request");
    data_edge_a: assert property (
        $changed(read_data_out) |-> $past(out_p || out_n))
        else $error("read data moved off an output edge");
    tristate_a: assert property (
        $fell(read_data_oe) |->
        $past(out_p) && $past(s_ff.st) == dps_pkg::ST_TAIL)
        else $error("read bus released early");
    // old array word compared: a commit in the launch cycle is not forwarded
    upper_word_a: assert property (
        hi_launch_s |=>
        read_data_out == $past(mem[{act_a, 1'h1}]))
        else $error("upper word not launched on its edge");
    echo_src_a: assert property (
        !$past(srst) |->
        echo_strobe_pos == $past(s_ff.single ? input_timing_pos
                                             : output_timing_pos))
        else $error("echo strobe not taken from the timing pair");
endmodule : dps_port

/* tb/dps_ctl_model.sv */
/*
 * controller side clock pins: input and output timing pairs, zero skew.
 * assumes clk is the system clock and srst its synchronous reset.
 */
`timescale 1ns/1ns
module dps_ctl_model (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic single_clock_mode,
    output logic      input_timing_pos,
    output logic      input_timing_neg,
    output logic      output_timing_pos,
    output logic      output_timing_neg
);
    logic [1:0] cnt_ff;
    // four clk per pin cycle keeps each pin to one change per clk
    always_ff @(posedge clk) begin
        cnt_ff <= srst ? 2'h0 : cnt_ff + 2'h1;
    end
    assign input_timing_pos  = cnt_ff[1];
    assign input_timing_neg  = ~cnt_ff[1];
    // single-clock mode: output pair tied high, only the input pair may time
    assign output_timing_pos = cnt_ff[1] | single_clock_mode;
    assign output_timing_neg = ~cnt_ff[1] | single_clock_mode;
endmodule : dps_ctl_model

/* tb/tb_dual_port_ddr_sram_port_timing.sv */
/*
 * self-checking bench for the port logic: writes, lane masks, reads in
 * both latency modes, echo strobes. assumes dps_ctl_model drives pins.
 */
`timescale 1ns/1ns
module tb_dual_port_ddr_sram_port_timing;
    logic        clk, srst, strap, rsel_n, wsel_n, single;
    logic        itp, itn, otp, otn, oe, ep, en, pll_on;
    logic [1:0]  lanes_n;
    logic [3:0]  addr;
    logic [17:0] wdat, rdat;
    int          n_fail, samples_checked;
    dps_port dut (.clk(clk), .srst(srst), .pll_bypass_n(strap),
        .single_clock_mode(single), .input_timing_pos(itp),
        .input_timing_neg(itn), .output_timing_pos(otp),
        .output_timing_neg(otn), .read_select_n(rsel_n),
        .write_select_n(wsel_n), .byte_lane_enable_n(lanes_n),
        .address(addr), .write_value_in(wdat), .read_data_out(rdat),
        .read_data_oe(oe), .echo_strobe_pos(ep), .echo_strobe_neg(en),
        .pll_enabled(pll_on));
    dps_ctl_model ctl (.clk(clk), .srst(srst),
        .single_clock_mode(single), .input_timing_pos(itp),
        .input_timing_neg(itn), .output_timing_pos(otp),
        .output_timing_neg(otn));
    ////////////////////////////////////////////////////////////////////
    task automatic chk1(string nm, logic e, logic s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask : chk1
    task automatic chkw(string nm, logic [17:0] e, logic [17:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask : chkw
    task automatic wrap_up;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // returns at the falling edge just after the pin went high
    task automatic wait_rise(bit neg);
        logic p;
        do begin
            p = neg ? itn : itp;
            @(negedge clk);
        end while (!((neg ? itn : itp) && !p));
    endtask : wait_rise
    ////////////////////////////////////////////////////////////////////
    task automatic do_reset(logic s, logic sc);
        srst = 1'h1;
        strap = s;
        single = sc;
        repeat (3) @(negedge clk);
        chk1("pll_enabled", s, pll_on);
        chk1("oe_reset", 1'h0, oe);
        srst = 1'h0;
        $display("reset done strap %0d single %0d", s, sc);
    endtask : do_reset
    task automatic wr(logic [3:0] a, logic [17:0] d0, d1, logic [1:0] l);
        wait_rise(1'b0);
        wsel_n = 1'h0;
        wdat = d0;
        lanes_n = 2'h0;
        wait_rise(1'b1);
        wsel_n = 1'h1;
        addr = a;
        wdat = d1;
        lanes_n = l;
        @(negedge clk);
        wdat = ~d1;
        addr = ~a;
        lanes_n = 2'h3;
        $display("write done");
    endtask : wr
    task automatic rd(logic [3:0] a, logic [17:0] lo, hi, int tl, toff);
        wait_rise(1'b0);
        rsel_n = 1'h0;
        addr = a;
        for (int i = 1; i <= toff; i++) begin
            @(negedge clk);
            if (i == 1) begin
                rsel_n = 1'h1;
                addr = ~a;
            end
            if (i == tl - 1) chk1("oe_pre", 1'h0, oe);
            if (i == tl) chk1("oe_lo", 1'h1, oe);
            if (i == tl) chkw("word_lo", lo, rdat);
            if (i == tl + 2) chkw("word_hi", hi, rdat);
            if (i == toff - 1) chk1("oe_hold", 1'h1, oe);
            if (i == toff) chk1("oe_off", 1'h0, oe);
        end
        $display("read done");
    endtask : rd
    task automatic echo_test;
        logic p, n;
        for (int i = 0; i < 8; i++) begin
            p = single ? itp : otp;
            n = single ? itn : otn;
            @(negedge clk);
            chk1("echo_pos", p, ep);
            chk1("echo_neg", n, en);
        end
        $display("echo done");
    endtask : echo_test
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 2000);
        n_fail++;
        wrap_up();
    end
    initial begin
        {n_fail, samples_checked} = '0;
        {rsel_n, wsel_n, lanes_n, addr, wdat} = {2'h3, 2'h3, 4'h0, 18'h0};
        do_reset(1'h1, 1'h0);
        echo_test();
        wr(4'h3, 18'h2a5a5, 18'h1c3c3, 2'h0);
        wr(4'h5, 18'h00111, 18'h3ffff, 2'h0);
        // lane 0 held off on the upper word keeps bits 8:0
        wr(4'h5, 18'h00222, 18'h15555, 2'h1);
        rd(4'h3, 18'h2a5a5, 18'h1c3c3, 7, 13);
        rd(4'h5, 18'h00222, 18'h155ff, 7, 13);
        do_reset(1'h0, 1'h0);
        wr(4'h9, 18'h30f0f, 18'h0cccc, 2'h0);
        rd(4'h9, 18'h30f0f, 18'h0cccc, 5, 9);
        do_reset(1'h1, 1'h1);
        echo_test();
        rd(4'h9, 18'h30f0f, 18'h0cccc, 7, 13);
        wrap_up();
    end
endmodule : tb_dual_port_ddr_sram_port_timing
